/* core/djk_pkg.sv */
// Shared constants, reset values and the next-state function of the dual J-K block.
`default_nettype none
package djk_pkg;
	localparam int unsigned DJK_NUM_ELEM = 2;
	localparam int unsigned DJK_SYNC_STAGES = 2;
	localparam int unsigned DJK_SYNC_FIELDS = 5;
	localparam logic DJK_STATE_RST = 1'h0;
	localparam logic DJK_CLK_RST = 1'h0;
	localparam logic DJK_STEER_RST = 1'h0;
	localparam logic DJK_ASYNC_RST = 1'h1;

	// Next stored level from the two steering inputs at a falling clock edge.
	function automatic logic djkNext(input logic cur, input logic j, input logic k);
		logic res;
		res = cur;
		unique case ({j, k})
			2'h0: res = cur;
			2'h2: res = 1'h1;
			2'h1: res = 1'h0;
			2'h3: res = ~cur;
		endcase
		return res;
	endfunction
endpackage : djk_pkg
`default_nettype wire

/* core/djk_sync.sv */
// Two-flop synchroniser for a bus of independent single-bit levels.
`default_nettype none
module djk_sync
	import djk_pkg::*;
#(
	parameter int unsigned WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} djk_sync_st_t;

	localparam djk_sync_st_t SYNC_RST = '{stage1: RST_VAL, stage2: RST_VAL};

	djk_sync_st_t st_r;
	djk_sync_st_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.stage1 = din;
		st_nxt.stage2 = st_r.stage1;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_r <= SYNC_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign dout = st_r.stage2;
endmodule // djk_sync
`default_nettype wire

/* core/djk_top.sv */
// Dual falling-edge J-K storage element with active-low asynchronous set and reset.
//
// Notes on behaviour
// - There are independent elements, each with its own clock, steering, set, reset and outputs.
// - At a falling element clock with set and reset inactive, J=K=0 holds, J alone sets, K alone resets.
// - At a falling element clock with set and reset inactive and J and K both high, the state and both outputs invert.
// - Steering changes while the element clock is steady do not touch the outputs.
// - Without a falling element clock and with set and reset inactive, both outputs hold.
// - Set low alone drives true high and inverted low; reset low alone drives the reverse.
// - Set and reset low together drive both outputs high, which ends when either is released.
`default_nettype none
module djk_top
	import djk_pkg::*;
#(
	parameter int unsigned NUM_ELEM = DJK_NUM_ELEM
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [NUM_ELEM-1:0] elemClk,
	input wire logic [NUM_ELEM-1:0] steerJ,
	input wire logic [NUM_ELEM-1:0] steerK,
	input wire logic [NUM_ELEM-1:0] asyncSetLow,
	input wire logic [NUM_ELEM-1:0] asyncResetLow,
	output logic [NUM_ELEM-1:0] stateTrue,
	output logic [NUM_ELEM-1:0] stateInv
);
	localparam int unsigned SW = DJK_SYNC_FIELDS * NUM_ELEM;
	localparam logic [SW-1:0] SYNC_RST = {
		{NUM_ELEM{DJK_ASYNC_RST}},
		{NUM_ELEM{DJK_ASYNC_RST}},
		{NUM_ELEM{DJK_STEER_RST}},
		{NUM_ELEM{DJK_STEER_RST}},
		{NUM_ELEM{DJK_CLK_RST}}
	};

	typedef struct packed {
		logic [NUM_ELEM-1:0] stored;
		logic [NUM_ELEM-1:0] outTrue;
		logic [NUM_ELEM-1:0] outInv;
		logic [NUM_ELEM-1:0] prevClk;
	} djk_top_st_t;

	localparam djk_top_st_t ST_RST = '{
		stored: {NUM_ELEM{DJK_STATE_RST}},
		outTrue: {NUM_ELEM{DJK_STATE_RST}},
		outInv: {NUM_ELEM{~DJK_STATE_RST}},
		prevClk: {NUM_ELEM{DJK_CLK_RST}}
	};

	logic [SW-1:0] syncOut;
	logic [NUM_ELEM-1:0] clkS;
	logic [NUM_ELEM-1:0] jS;
	logic [NUM_ELEM-1:0] kS;
	logic [NUM_ELEM-1:0] setS;
	logic [NUM_ELEM-1:0] rstS;
	logic [NUM_ELEM-1:0] fallEdge;

	djk_top_st_t st_r;
	djk_top_st_t st_nxt;

	// Every element pin crosses into the ref_clk domain before the state logic reads it; rst is used directly.
	djk_sync #(
		.WIDTH(SW),
		.RST_VAL(SYNC_RST)
	) u_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.din({asyncResetLow, asyncSetLow, steerK, steerJ, elemClk}),
		.dout(syncOut)
	);

	assign clkS = syncOut[0 +: NUM_ELEM];
	assign jS = syncOut[NUM_ELEM +: NUM_ELEM];
	assign kS = syncOut[2*NUM_ELEM +: NUM_ELEM];
	assign setS = syncOut[3*NUM_ELEM +: NUM_ELEM];
	assign rstS = syncOut[4*NUM_ELEM +: NUM_ELEM];

	// A falling edge is seen once, the cycle the synchronised clock goes from high to low.
	assign fallEdge = st_r.prevClk & ~clkS;

	always_comb begin
		st_nxt = st_r;
		for (int i = 0; i < NUM_ELEM; i++) begin
			st_nxt.prevClk[i] = clkS[i];
			if (!setS[i] && !rstS[i]) begin
				st_nxt.outTrue[i] = 1'h1;
				st_nxt.outInv[i] = 1'h1;
			end else begin
				if (!setS[i]) begin
					st_nxt.stored[i] = 1'h1;
				end else if (!rstS[i]) begin
					st_nxt.stored[i] = 1'h0;
				end else if (fallEdge[i]) begin
					st_nxt.stored[i] = djkNext(st_r.stored[i], jS[i], kS[i]);
				end
				// Outputs follow the stored level, so they hold when nothing acts.
				st_nxt.outTrue[i] = st_nxt.stored[i];
				st_nxt.outInv[i] = ~st_nxt.stored[i];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_r <= ST_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign stateTrue = st_r.outTrue;
	assign stateInv = st_r.outInv;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	// Checks on the raw pins allow for the two synchroniser stages ahead of the state flop.
	for (genvar g = 0; g < NUM_ELEM; g++) begin : g_chk
		sequence sInactive2;
			(setS[g] && rstS[g]) [*2];
		endsequence

		sequence sToggleEdge;
			sInactive2 ##0 (fallEdge[g] && jS[g] && kS[g]);
		endsequence

		sequence sQuietClock;
			sInactive2 ##0 !fallEdge[g];
		endsequence

		sequence sSteerWiggle;
			sQuietClock ##0 ($changed(jS[g]) || $changed(kS[g]));
		endsequence

		sequence sPinSet;
			(!asyncSetLow[g] && asyncResetLow[g]) [*3];
		endsequence

		sequence sPinBoth;
			(!asyncSetLow[g] && !asyncResetLow[g]) [*3];
		endsequence

		sequence sPinReset;
			(asyncSetLow[g] && !asyncResetLow[g]) [*3];
		endsequence

		sequence sToggleFromLow;
			sToggleEdge ##0 !stateTrue[g];
		endsequence

		sequence sToggleFromHigh;
			sToggleEdge ##0 stateTrue[g];
		endsequence

		a_toggle_inverts: assert property (
			sToggleEdge |=> (stateTrue[g] != $past(stateTrue[g]))
				&& (stateInv[g] != $past(stateInv[g])))
			else $error("toggle edge did not invert both outputs");

		a_set_on_fall: assert property (
			(setS[g] && rstS[g] && fallEdge[g] && jS[g] && !kS[g])
				|=> stateTrue[g] && !stateInv[g])
			else $error("J alone at falling edge did not set");

		a_reset_on_fall: assert property (
			(setS[g] && rstS[g] && fallEdge[g] && !jS[g] && kS[g])
				|=> !stateTrue[g] && stateInv[g])
			else $error("K alone at falling edge did not reset");

		a_hold_on_fall: assert property (
			(sInactive2 ##0 (fallEdge[g] && !jS[g] && !kS[g]))
				|=> $stable(stateTrue[g]) && $stable(stateInv[g]))
			else $error("J and K low at falling edge changed the outputs");

		a_quiet_hold: assert property (
			sQuietClock |=> $stable(stateTrue[g]) && $stable(stateInv[g]))
			else $error("outputs moved without a falling edge");

		a_steer_ignored: assert property (
			sSteerWiggle |=> $stable(stateTrue[g]))
			else $error("steering change on steady clock moved the output");

		a_pin_set_latency: assert property (
			sPinSet |=> stateTrue[g] && !stateInv[g])
			else $error("set pin low did not force true high within three cycles");

		a_async_reset: assert property (
			(setS[g] && !rstS[g]) |=> !stateTrue[g] && stateInv[g])
			else $error("reset low did not force true low and inverted high");

		a_pin_reset_latency: assert property (
			sPinReset |=> !stateTrue[g] && stateInv[g])
			else $error("reset pin low did not force true low within three cycles");

		a_set_override: assert property (
			(!setS[g] && rstS[g]) |=> stateTrue[g] && !stateInv[g])
			else $error("set low did not force true high and inverted low");

		a_both_low_sync: assert property (
			(!setS[g] && !rstS[g]) |=> stateTrue[g] && stateInv[g])
			else $error("synchronised set and reset low did not give two high outputs");

		a_out_complement: assert property (
			(setS[g] || rstS[g]) |=> stateInv[g] == ~stateTrue[g])
			else $error("outputs not complementary with an override inactive");

		a_toggle_rises: assert property (
			sToggleFromLow |=> stateTrue[g] && !stateInv[g])
			else $error("toggle from low did not set the element");

		a_toggle_falls: assert property (
			sToggleFromHigh |=> !stateTrue[g] && stateInv[g])
			else $error("toggle from high did not reset the element");

		a_both_low_high: assert property (
			sPinBoth |=> stateTrue[g] && stateInv[g])
			else $error("set and reset low did not drive both outputs high");

		a_nonstable_exit: assert property (
			($past(!setS[g] && !rstS[g]) && (setS[g] || rstS[g]))
				|=> stateInv[g] == ~stateTrue[g])
			else $error("both-high condition outlived the release");
	end
endmodule // djk_top
`default_nettype wire

/* verification/djk_drv.sv */
// Model of the surrounding logic that drives the element pins.
`default_nettype none
module djk_drv
	import djk_pkg::*;
(
	input wire logic ref_clk,
	output var logic [DJK_NUM_ELEM-1:0] eClk,
	output var logic [DJK_NUM_ELEM-1:0] eJ,
	output var logic [DJK_NUM_ELEM-1:0] eK,
	output var logic [DJK_NUM_ELEM-1:0] setLow,
	output var logic [DJK_NUM_ELEM-1:0] resetLow
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		eClk = '0;
		eJ = '0;
		eK = '0;
		setLow = '1;
		resetLow = '1;
	end
	// Sets the steering and override levels of one element, then lets them settle.
	task automatic pins(input int e, input logic j, input logic k, input logic s, input logic r);
		@(negedge ref_clk);
		if (!setLow[e] && !resetLow[e] && s && r) begin
			setLow[e] = 1'h1;
			@(negedge ref_clk);
		end
		eJ[e] = j;
		eK[e] = k;
		setLow[e] = s;
		resetLow[e] = r;
		repeat (5) @(negedge ref_clk);
	endtask
	// Gives one element clock pulse; the clock stands low between pulses.
	task automatic fall(input int e);
		@(negedge ref_clk);
		eClk[e] = 1'h1;
		repeat (3) @(negedge ref_clk);
		eClk[e] = 1'h0;
		repeat (5) @(negedge ref_clk);
	endtask
	// Moves one element clock to a level and leaves it there.
	task automatic level(input int e, input logic c);
		@(negedge ref_clk);
		eClk[e] = c;
		repeat (5) @(negedge ref_clk);
	endtask
endmodule // djk_drv
`default_nettype wire

/* verification/djk_top_tb.sv */
// Self-checking testbench of the dual J-K block.
`default_nettype none
module djk_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk;
	logic rst;
	logic [1:0] eClk, eJ, eK, setLow, resetLow, sTrue, sInv;
	logic st [2];
	int mismatches = 0;
	int numChecks = 0;
	int cycles = 0;
	djk_drv drv_u (.ref_clk(ref_clk), .eClk(eClk), .eJ(eJ), .eK(eK), .setLow(setLow),
		.resetLow(resetLow));
	djk_top dut_u (.ref_clk(ref_clk), .rst(rst), .elemClk(eClk), .steerJ(eJ), .steerK(eK),
		.asyncSetLow(setLow), .asyncResetLow(resetLow), .stateTrue(sTrue), .stateInv(sInv));
	task automatic complete_run();
		if (mismatches == 0 && numChecks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic cmp(input int e, input logic [1:0] exp);
		numChecks++;
		if ({sTrue[e], sInv[e]} !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h exp %h", $time, {sTrue[e], sInv[e]}, exp);
		end
	endtask
	task automatic scSteer(input int e);
		logic [9:0] seq;
		logic [1:0] jk;
		seq = 10'h23d;
		for (int i = 0; i < 5; i++) begin
			jk = seq[9-2*i -: 2];
			drv_u.pins(e, jk[1], jk[0], 1'h1, 1'h1);
			drv_u.fall(e);
			st[e] = (jk == 2'h3) ? ~st[e] : (jk == 2'h2) ? 1'h1 : (jk == 2'h1) ? 1'h0 : st[e];
			cmp(e, {st[e], ~st[e]});
			cmp(1 - e, {st[1-e], ~st[1-e]});
		end
	endtask
	task automatic scSteady(input int e);
		drv_u.pins(e, 1'h1, 1'h1, 1'h1, 1'h1);
		cmp(e, {st[e], ~st[e]});
		drv_u.pins(e, ~st[e], st[e], 1'h1, 1'h1);
		cmp(e, {st[e], ~st[e]});
		drv_u.level(e, 1'h1);
		cmp(e, {st[e], ~st[e]});
		drv_u.pins(e, ~st[e], st[e], 1'h1, 1'h1);
		cmp(e, {st[e], ~st[e]});
		drv_u.pins(e, 1'h1, 1'h1, 1'h1, 1'h1);
		cmp(e, {st[e], ~st[e]});
		drv_u.pins(e, 1'h0, 1'h0, 1'h1, 1'h1);
		drv_u.level(e, 1'h0);
		cmp(e, {st[e], ~st[e]});
	endtask
	task automatic scAsync(input int e);
		drv_u.pins(e, 1'h1, 1'h1, 1'h0, 1'h1);
		cmp(e, 2'h2);
		drv_u.fall(e);
		cmp(e, 2'h2);
		drv_u.pins(e, 1'h0, 1'h0, 1'h1, 1'h0);
		cmp(e, 2'h1);
		drv_u.pins(e, 1'h0, 1'h0, 1'h0, 1'h0);
		cmp(e, 2'h3);
		drv_u.pins(e, 1'h0, 1'h0, 1'h1, 1'h0);
		cmp(e, 2'h1);
		drv_u.pins(e, 1'h0, 1'h0, 1'h1, 1'h1);
		st[e] = 1'h0;
		cmp(e, 2'h1);
	endtask
	initial begin
		ref_clk = 1'h0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			complete_run();
		end
	end
	initial begin
		rst = 1'h1;
		st[0] = 1'h0;
		st[1] = 1'h0;
		repeat (20) @(negedge ref_clk);
		rst = 1'h0;
		repeat (4) @(negedge ref_clk);
		cmp(0, 2'h1);
		cmp(1, 2'h1);
		for (int e = 0; e < 2; e++) begin
			scSteer(e);
			scSteady(e);
			scAsync(e);
		end
		complete_run();
	end
endmodule // djk_top_tb
`default_nettype wire
